// >>> core/sasc_defines.vh
/*
 * Register map, field positions, reset values and timing counts of the
 * asynchronous serial status and control block.
 * Assumes inclusion by the design file only; definitions only.
 */
`ifndef SASC_DEFINES_VH
`define SASC_DEFINES_VH

// register addresses
`define SASC_ADDR_STATUS   3'h0
`define SASC_ADDR_DATA     3'h1
`define SASC_ADDR_FRAME    3'h2
`define SASC_ADDR_ENABLE   3'h3
`define SASC_ADDR_DIVISOR  3'h4

// status fields
`define SASC_ST_TX_EMPTY   7
`define SASC_ST_TX_DONE    6
`define SASC_ST_RX_READY   5
`define SASC_ST_IDLE       4
`define SASC_ST_OVERRUN    3
`define SASC_ST_NOISE      2
`define SASC_ST_FRAMING    1
`define SASC_ST_PARITY     0

// frame control fields
`define SASC_FC_RX_NINTH   7
`define SASC_FC_TX_NINTH   6
`define SASC_FC_LP_OFF     5
`define SASC_FC_LONG_WORD  4
`define SASC_FC_WAKE_ADDR  3
`define SASC_FC_PARITY_ON  2
`define SASC_FC_ODD_SEL    1
`define SASC_FC_PAR_IRQ    0

// enable control fields
`define SASC_EC_TXE_IRQ    7
`define SASC_EC_TXD_IRQ    6
`define SASC_EC_RX_IRQ     5
`define SASC_EC_IDLE_IRQ   4
`define SASC_EC_TX_ON      3
`define SASC_EC_RX_ON      2
`define SASC_EC_MUTE       1
`define SASC_EC_BREAK      0

// reset values
`define SASC_RST_STATUS    8'hC0
`define SASC_RST_FRAME     8'h00
`define SASC_RST_ENABLE    8'h00
`define SASC_RST_DIVISOR   16'h000F

// oversampling: sixteen ticks per bit
`define SASC_OVERSAMPLE    5'h10
`define SASC_MID_SAMPLE    4'h7

`endif

// >>> core/sasc_serial.v
/*
 * Asynchronous serial interface: status flags, frame and enable control,
 * transmitter and receiver with parity, mute/wake-up, break and preamble.
 * Assumes a plain register port (read data one cycle after the strobe) and
 * a remote node on RXD_IN that is asynchronous to SYS_CLK_IN.
 */
`timescale 1ns/1ps
`include "sasc_defines.vh"

// How it works
// - transmit-complete set after data frame; sequence clears
// - preamble or break leaves transmit-complete alone
// - receive-ready set on buffer load; sequence clears
// - idle flag re-arms only after receive-ready
// - overrun keeps buffered word, raises flag
// - noise flag, no own interrupt
// - framing flag; overrun alone when both
// - parity-error flag with its interrupt enable
// - ninth bits held in frame control
// - low-power bit stops link after byte
// - word length eight or nine bits
// - wake method idle line or address mark
// - parity in top data bit, checked
// - even or odd parity, latched per byte
// - shared interrupt from enabled conditions
// - one bit delay; enable pulse while transmitter busy queues preamble
// - receiver enable starts start-bit search
// - mute bit; hardware clears on wake
// - address wake ignores mute writes while ready
// - transmit-empty set on buffer transfer
// - break pulse sends one break word
// - mute blocks receive flags and interrupts
module sasc_serial #(
   parameter DIV_W = 16
) (
   input  wire       SYS_CLK_IN,
   input  wire       RESET_N_IN,
   input  wire [2:0] ADDR_IN,
   input  wire [7:0] WDATA_IN,
   input  wire       WR_IN,
   input  wire       RD_IN,
   output reg  [7:0] RDATA_OUT,
   input  wire       RXD_IN,
   output reg        TXD_OUT,
   output reg        IRQ_OUT
);

   localparam TX_IDLE  = 3'h0;
   localparam TX_DELAY = 3'h1;
   localparam TX_SHIFT = 3'h2;
   localparam TX_PRE   = 3'h3;
   localparam TX_BRK   = 3'h4;

   localparam RX_HUNT  = 2'h0;
   localparam RX_SHIFT = 2'h1;

   reg  [7:0]       status_reg;
   reg  [7:0]       frame_reg;
   reg  [7:0]       enable_reg;
   reg  [DIV_W-1:0] divisor_reg;
   reg              armed_reg;
   reg              idle_armed_reg;
   reg  [7:0]       tx_buffer_reg;
   reg  [7:0]       rx_buffer_reg;
   reg  [2:0]       rxd_sync_reg;

   // transmit side
   reg  [2:0]       tx_state_reg;
   reg  [DIV_W-1:0] tx_div_reg;
   reg  [3:0]       tx_tick_reg;
   reg  [3:0]       tx_bit_reg;
   reg  [10:0]      tx_shift_reg;
   reg  [3:0]       tx_len_reg;
   reg              tx_pend_pre_reg;
   reg              tx_pend_brk_reg;
   reg              tx_data_reg;

   // receive side
   reg  [1:0]       rx_state_reg;
   reg  [DIV_W-1:0] rx_div_reg;
   reg  [3:0]       rx_tick_reg;
   reg  [3:0]       rx_bit_reg;
   reg  [9:0]       rx_shift_reg;
   reg  [3:0]       rx_len_reg;
   reg              rx_par_on_reg;
   reg              rx_odd_reg;
   reg              rx_long_reg;
   reg              rx_noise_reg;
   reg  [3:0]       idle_cnt_reg;
   reg  [3:0]       ones_cnt_reg;
   reg              rx_line_reg;

   wire rxd_now  = rxd_sync_reg[2];
   wire rxd_ok   = (rxd_sync_reg[1] == rxd_sync_reg[2]);
   wire rx_muted = enable_reg[`SASC_EC_MUTE];
   wire lp_off   = frame_reg[`SASC_FC_LP_OFF];
   wire rd_data  = RD_IN & (ADDR_IN == `SASC_ADDR_DATA);
   wire wr_data  = WR_IN & (ADDR_IN == `SASC_ADDR_DATA);
   wire rd_stat  = RD_IN & (ADDR_IN == `SASC_ADDR_STATUS);
   wire tx_tickp = (tx_div_reg == {DIV_W{1'b0}});
   wire rx_tickp = (rx_div_reg == {DIV_W{1'b0}});
   wire tx_bit_end = tx_tickp & (tx_tick_reg == 4'hF);
   wire wake_addr = frame_reg[`SASC_FC_WAKE_ADDR];

   // receive frame decode at the stop bit
   // the last sample is still on the line at rx_end, so it is folded in here
   wire [9:0] rx_frame = rx_long_reg ? {rx_line_reg, rx_shift_reg[9:1]} : {1'b0, rx_line_reg, rx_shift_reg[9:2]};
   wire [8:0] rx_word  = rx_long_reg ? rx_frame[8:0] : {1'b0, rx_frame[7:0]};
   wire       rx_stop  = rx_long_reg ? rx_frame[9] : rx_frame[8];
   wire       rx_msb   = rx_long_reg ? rx_frame[8] : rx_frame[7];
   wire       rx_par   = ^rx_word ^ rx_odd_reg;
   wire       rx_end   = (rx_state_reg == RX_SHIFT) & rx_tickp & (rx_tick_reg == `SASC_MID_SAMPLE)
                         & (rx_bit_reg == rx_len_reg);
   wire       rx_break = rx_end & (rx_word == 9'h000) & ~rx_stop;
   wire       wake_by_addr = rx_muted & wake_addr & rx_msb & rx_end;
   wire       rx_take  = rx_end & (~rx_muted | wake_by_addr);
   wire       idle_seen = rx_line_reg & (idle_cnt_reg == rx_len_reg) & rx_tickp
                          & (ones_cnt_reg == 4'hF) & enable_reg[`SASC_EC_RX_ON];
   wire       wake_by_idle = rx_muted & ~wake_addr & idle_seen;

   // transmit load/end events
   wire tx_load  = (tx_state_reg == TX_IDLE) & ~status_reg[`SASC_ST_TX_EMPTY]
                   & enable_reg[`SASC_EC_TX_ON] & ~lp_off & ~tx_pend_pre_reg & ~tx_pend_brk_reg;
   wire tx_frame_end = tx_bit_end & (tx_bit_reg == tx_len_reg)
                       & ((tx_state_reg == TX_SHIFT) | (tx_state_reg == TX_PRE)
                          | (tx_state_reg == TX_BRK));

   // parity inserted on the top data bit
   wire       long_w  = frame_reg[`SASC_FC_LONG_WORD];
   wire [8:0] tx_raw  = {frame_reg[`SASC_FC_TX_NINTH], tx_buffer_reg};
   wire       tx_p8   = ^tx_buffer_reg[7:0] ^ frame_reg[`SASC_FC_ODD_SEL];
   wire       tx_p7   = ^tx_buffer_reg[6:0] ^ frame_reg[`SASC_FC_ODD_SEL];
   wire [8:0] tx_word = ~frame_reg[`SASC_FC_PARITY_ON] ? tx_raw :
                        long_w ? {tx_p8, tx_buffer_reg} : {1'b0, tx_p7, tx_buffer_reg[6:0]};

   reg [7:0] status_next;
   reg [7:0] enable_next;

   always @* begin
      status_next = status_reg;
      // clears first so that a same-cycle hardware set wins
      if (armed_reg & wr_data) begin
         status_next[`SASC_ST_TX_EMPTY] = 1'b0;
         status_next[`SASC_ST_TX_DONE]  = 1'b0;
      end
      if (armed_reg & (rd_data | wr_data))
         status_next[`SASC_ST_PARITY] = 1'b0;
      if (armed_reg & rd_data)
         status_next[5:1] = 5'h00;
      if (tx_load)
         status_next[`SASC_ST_TX_EMPTY] = 1'b1;
      if (tx_frame_end & (tx_state_reg == TX_SHIFT))
         status_next[`SASC_ST_TX_DONE] = 1'b1;
      if (rx_take) begin
         if (status_reg[`SASC_ST_RX_READY] & ~wake_by_addr) begin
            status_next[`SASC_ST_OVERRUN] = 1'b1;
         end else begin
            status_next[`SASC_ST_RX_READY] = 1'b1;
            if (rx_noise_reg)
               status_next[`SASC_ST_NOISE] = 1'b1;
            if (~rx_stop | rx_break)
               status_next[`SASC_ST_FRAMING] = 1'b1;
            if (rx_par_on_reg & rx_par)
               status_next[`SASC_ST_PARITY] = 1'b1;
         end
      end
      if (idle_seen & ~rx_muted & idle_armed_reg)
         status_next[`SASC_ST_IDLE] = 1'b1;
   end

   always @* begin
      enable_next = enable_reg;
      if (WR_IN & (ADDR_IN == `SASC_ADDR_ENABLE)) begin
         enable_next = WDATA_IN;
         if (wake_addr & status_reg[`SASC_ST_RX_READY])
            enable_next[`SASC_EC_MUTE] = enable_reg[`SASC_EC_MUTE];
      end
      if (wake_by_idle | wake_by_addr)
         enable_next[`SASC_EC_MUTE] = 1'b0;
   end

   // registers, read port and the shared interrupt
   always @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) begin
         status_reg     <= `SASC_RST_STATUS;
         frame_reg      <= `SASC_RST_FRAME;
         enable_reg     <= `SASC_RST_ENABLE;
         divisor_reg    <= `SASC_RST_DIVISOR;
         armed_reg      <= 1'b0;
         idle_armed_reg <= 1'b1;
         tx_buffer_reg  <= 8'h00;
         rx_buffer_reg  <= 8'h00;
         rxd_sync_reg   <= 3'h7;
         RDATA_OUT      <= 8'h00;
         IRQ_OUT        <= 1'b0;
      end else begin
         rxd_sync_reg <= {rxd_sync_reg[1:0], RXD_IN};
         status_reg   <= status_next;
         enable_reg   <= enable_next;
         if (rd_stat)
            armed_reg <= 1'b1;
         else if (rd_data | wr_data)
            armed_reg <= 1'b0;
         if (status_next[`SASC_ST_RX_READY] & ~status_reg[`SASC_ST_RX_READY])
            idle_armed_reg <= 1'b1;
         else if (idle_seen)
            idle_armed_reg <= 1'b0;
         if (WR_IN & (ADDR_IN == `SASC_ADDR_FRAME))
            frame_reg[6:0] <= WDATA_IN[6:0];
         if (WR_IN & (ADDR_IN == `SASC_ADDR_DIVISOR))
            divisor_reg <= {{(DIV_W-8){1'b0}}, WDATA_IN};
         if (wr_data)
            tx_buffer_reg <= WDATA_IN;
         if (rx_take & ~(status_reg[`SASC_ST_RX_READY] & ~wake_by_addr)) begin
            rx_buffer_reg <= rx_word[7:0];
            frame_reg[`SASC_FC_RX_NINTH] <= rx_word[8];
         end
         case (ADDR_IN)
            `SASC_ADDR_STATUS:  RDATA_OUT <= status_reg;
            `SASC_ADDR_DATA:    RDATA_OUT <= rx_buffer_reg;
            `SASC_ADDR_FRAME:   RDATA_OUT <= frame_reg;
            `SASC_ADDR_ENABLE:  RDATA_OUT <= enable_reg;
            `SASC_ADDR_DIVISOR: RDATA_OUT <= divisor_reg[7:0];
            default:            RDATA_OUT <= 8'h00;
         endcase
         IRQ_OUT <= (status_reg[`SASC_ST_TX_EMPTY] & enable_reg[`SASC_EC_TXE_IRQ])
                  | (status_reg[`SASC_ST_TX_DONE] & enable_reg[`SASC_EC_TXD_IRQ])
                  | (~rx_muted & status_reg[`SASC_ST_RX_READY] & enable_reg[`SASC_EC_RX_IRQ])
                  | (~rx_muted & status_reg[`SASC_ST_OVERRUN] & enable_reg[`SASC_EC_RX_IRQ])
                  | (~rx_muted & status_reg[`SASC_ST_IDLE] & enable_reg[`SASC_EC_IDLE_IRQ])
                  | (~rx_muted & status_reg[`SASC_ST_PARITY] & frame_reg[`SASC_FC_PAR_IRQ]);
      end
   end

   // transmitter: sixteen ticks per bit
   always @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) begin
         tx_state_reg    <= TX_IDLE;
         tx_div_reg      <= {DIV_W{1'b0}};
         tx_tick_reg     <= 4'h0;
         tx_bit_reg      <= 4'h0;
         tx_shift_reg    <= 11'h7FF;
         tx_len_reg      <= 4'h9;
         tx_pend_pre_reg <= 1'b0;
         tx_pend_brk_reg <= 1'b0;
         tx_data_reg     <= 1'b1;
         TXD_OUT         <= 1'b1;
      end else begin
         tx_div_reg <= tx_tickp ? divisor_reg : tx_div_reg - {{(DIV_W-1){1'b0}}, 1'b1};
         if (tx_tickp & (tx_state_reg != TX_IDLE))
            tx_tick_reg <= tx_tick_reg + 4'h1;
         if (WR_IN & (ADDR_IN == `SASC_ADDR_ENABLE)) begin
            if (~WDATA_IN[`SASC_EC_TX_ON] & enable_reg[`SASC_EC_TX_ON] & (tx_state_reg != TX_IDLE))
               tx_pend_pre_reg <= 1'b1;
            if (~WDATA_IN[`SASC_EC_BREAK] & enable_reg[`SASC_EC_BREAK])
               tx_pend_brk_reg <= 1'b1;
         end
         case (tx_state_reg)
            TX_IDLE: begin
               tx_tick_reg <= 4'h0;
               tx_bit_reg  <= 4'h0;
               if (enable_reg[`SASC_EC_TX_ON] & ~lp_off &
                   (tx_load | tx_pend_pre_reg | tx_pend_brk_reg))
                  tx_state_reg <= TX_DELAY;
               if (tx_load) begin
                  tx_data_reg  <= 1'b1;
                  tx_len_reg   <= long_w ? 4'hA : 4'h9;
                  tx_shift_reg <= long_w ? {1'b1, tx_word, 1'b0}
                                         : {2'b11, tx_word[7:0], 1'b0};
               end
            end
            TX_DELAY: begin
               if (tx_bit_end) begin
                  tx_bit_reg <= 4'h0;
                  if (tx_pend_brk_reg) begin
                     tx_state_reg <= TX_BRK;
                     tx_len_reg   <= long_w ? 4'hA : 4'h9;
                  end else if (tx_pend_pre_reg) begin
                     tx_state_reg <= TX_PRE;
                     tx_len_reg   <= long_w ? 4'hA : 4'h9;
                  end else begin
                     tx_state_reg <= TX_SHIFT;
                  end
               end
            end
            default: begin
               if (tx_bit_end) begin
                  tx_bit_reg   <= tx_bit_reg + 4'h1;
                  tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
               end
               if (tx_frame_end) begin
                  // queued preamble or break goes out after the data word
                  if (tx_state_reg == TX_BRK)
                     tx_pend_brk_reg <= 1'b0;
                  if (tx_state_reg == TX_PRE)
                     tx_pend_pre_reg <= 1'b0;
                  tx_state_reg <= TX_IDLE;
               end
            end
         endcase
         if (tx_state_reg == TX_SHIFT)
            TXD_OUT <= tx_shift_reg[0];
         else if (tx_state_reg == TX_BRK)
            TXD_OUT <= 1'b0;
         else
            TXD_OUT <= 1'b1;
      end
   end

   // receiver: hunts for a start bit, samples mid-bit
   always @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) begin
         rx_state_reg  <= RX_HUNT;
         rx_div_reg    <= {DIV_W{1'b0}};
         rx_tick_reg   <= 4'h0;
         rx_bit_reg    <= 4'h0;
         rx_shift_reg  <= 10'h000;
         rx_len_reg    <= 4'h9;
         rx_par_on_reg <= 1'b0;
         rx_odd_reg    <= 1'b0;
         rx_long_reg   <= 1'b0;
         rx_noise_reg  <= 1'b0;
         idle_cnt_reg  <= 4'h0;
         ones_cnt_reg  <= 4'h0;
         rx_line_reg   <= 1'b1;
      end else begin
         rx_div_reg <= rx_tickp ? divisor_reg : rx_div_reg - {{(DIV_W-1){1'b0}}, 1'b1};
         if (rxd_ok)
            rx_line_reg <= rxd_now;
         // idle: a full frame time of ones counted in bit ticks
         if (~rx_line_reg | (rx_state_reg != RX_HUNT)) begin
            ones_cnt_reg <= 4'h0;
            idle_cnt_reg <= 4'h0;
         end else if (rx_tickp) begin
            ones_cnt_reg <= ones_cnt_reg + 4'h1;
            if ((ones_cnt_reg == 4'hF) & (idle_cnt_reg != rx_len_reg))
               idle_cnt_reg <= idle_cnt_reg + 4'h1;
         end
         case (rx_state_reg)
            RX_HUNT: begin
               rx_tick_reg  <= 4'h0;
               rx_bit_reg   <= 4'h0;
               rx_noise_reg <= 1'b0;
               if (enable_reg[`SASC_EC_RX_ON] & ~lp_off & ~rx_line_reg) begin
                  rx_state_reg  <= RX_SHIFT;
                  rx_len_reg    <= long_w ? 4'hA : 4'h9;
                  rx_long_reg   <= long_w;
                  rx_par_on_reg <= frame_reg[`SASC_FC_PARITY_ON];
                  rx_odd_reg    <= frame_reg[`SASC_FC_ODD_SEL];
               end
            end
            RX_SHIFT: begin
               if (rx_tickp) begin
                  rx_tick_reg <= rx_tick_reg + 4'h1;
                  if (rx_tick_reg == `SASC_MID_SAMPLE) begin
                     if (~rxd_ok)
                        rx_noise_reg <= 1'b1;
                     if (rx_bit_reg == 4'h0) begin
                        if (rx_line_reg)
                           rx_state_reg <= RX_HUNT;                        // false start
                     end else begin
                        rx_shift_reg <= {rx_line_reg, rx_shift_reg[9:1]};
                     end
                     if (rx_bit_reg == rx_len_reg)
                        rx_state_reg <= RX_HUNT;
                     rx_bit_reg <= rx_bit_reg + 4'h1;
                  end
               end
               if (rx_end & ~rx_long_reg)
                  rx_shift_reg <= {1'b0, rx_line_reg, rx_shift_reg[9:2]};
            end
            default: rx_state_reg <= RX_HUNT;
         endcase
      end
   end

endmodule

// >>> verification/sasc_node.sv
/* remote serial node: sends frames on the receive line, captures frames
   from the transmit line. assumes the same bit time as the block. */
`timescale 1ns/1ps
module sasc_node #(
   parameter BIT_NS = 64
) (
   input  wire txd_in,
   output reg  rxd_out
);
   reg [9:0] cap;
   integer   seen;
   integer   i;

   initial begin
      rxd_out = 1'b1;
      seen = 0;
   end

   // ten samples: data, stop, then the following bit (idle in 8-bit frames)
   always begin
      @(negedge txd_in);
      #(BIT_NS / 2);
      for (i = 0; i < 10; i = i + 1) begin
         #(BIT_NS);
         cap[i] = txd_in;
      end
      seen = seen + 1;
   end

   task send(input [8:0] d, input integer n, input stop);
      integer j;
      begin
         rxd_out = 1'b0;
         #(BIT_NS);
         for (j = 0; j < n; j = j + 1) begin
            rxd_out = d[j];
            #(BIT_NS);
         end
         rxd_out = stop;
         #(BIT_NS);
         rxd_out = 1'b1;
         #(BIT_NS);
      end
   endtask
endmodule

// >>> verification/sasc_serial_chk.sv
/* port checker for sasc_serial, bound to every instance.
   assumes software sets the divisor to 00 before bit timing is judged. */
`timescale 1ns/1ps
module sasc_serial_chk #(
   parameter DIV_W = 16
) (
   input wire       SYS_CLK_IN,
   input wire       RESET_N_IN,
   input wire [2:0] ADDR_IN,
   input wire [7:0] WDATA_IN,
   input wire       WR_IN,
   input wire       RD_IN,
   input wire [7:0] RDATA_OUT,
   input wire       RXD_IN,
   input wire       TXD_OUT,
   input wire       IRQ_OUT
);
   reg [7:0] fr_reg;
   reg [7:0] en_reg;
   reg [7:0] dv_reg;
   reg [7:0] off_cnt_reg;

   default clocking @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (!RESET_N_IN);

   function automatic irq_of(input [7:0] st, input [7:0] en, input [7:0] fr);
      irq_of = (st[7] & en[7]) | (st[6] & en[6]) | (en[5] & (st[5] | st[3])) | (st[4] & en[4]) | (st[0] & fr[0]);
   endfunction

   // shadows of software writes; bits hardware may change are masked below
   always @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) begin
         fr_reg <= 8'h00;
         en_reg <= 8'h00;
         dv_reg <= 8'h0F;
      end else if (WR_IN) begin
         if (ADDR_IN == 3'h2)
            fr_reg <= WDATA_IN;
         if (ADDR_IN == 3'h3)
            en_reg <= WDATA_IN;
         if (ADDR_IN == 3'h4)
            dv_reg <= WDATA_IN;
      end
   end

   // only counted at the fast divisor, so a frame draining after disable fits
   always @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN || en_reg[3] || dv_reg != 8'h00)
         off_cnt_reg <= 8'h00;
      else if (off_cnt_reg != 8'hFF)
         off_cnt_reg <= off_cnt_reg + 8'h01;
   end

   a_reset_outputs: assert property ($rose(RESET_N_IN) |-> TXD_OUT && !IRQ_OUT && RDATA_OUT == 8'h00)
      else $error("outputs not idle after reset");
   a_unmapped_zero: assert property (RD_IN && ADDR_IN > 3'h4 |=> RDATA_OUT == 8'h00)
      else $error("unmapped read not zero");
   a_frame_readback: assert property (RD_IN && ADDR_IN == 3'h2 |=> RDATA_OUT[6:0] == $past(fr_reg[6:0]))
      else $error("frame control readback wrong");
   a_enable_readback: assert property (RD_IN && ADDR_IN == 3'h3 |=> (RDATA_OUT & 8'hFD) == ($past(en_reg) & 8'hFD))
      else $error("enable control readback wrong");
   a_irq_from_status: assert property (RD_IN && ADDR_IN == 3'h0 && !en_reg[1] |=> IRQ_OUT == irq_of(RDATA_OUT, $past(en_reg), $past(fr_reg)))
      else $error("interrupt disagrees with status and enables");
   a_irq_all_masked: assert property ($stable(en_reg) && $stable(fr_reg) && (en_reg & 8'hF0) == 8'h00 && !fr_reg[0] |-> !IRQ_OUT)
      else $error("interrupt with all enables clear");
   a_txd_idle_off: assert property (off_cnt_reg == 8'hFF |-> TXD_OUT)
      else $error("line not idle with transmitter off");
   a_bit_stable: assert property ($changed(TXD_OUT) && dv_reg == 8'h00 |=> $stable(TXD_OUT)[*8] ##1 $stable(TXD_OUT)[*7])
      else $error("line bit shorter than sixteen clocks");

   c_tx_start: cover property ($fell(TXD_OUT));
   c_irq_rise: cover property ($rose(IRQ_OUT));
   c_rx_ready: cover property (RD_IN && ADDR_IN == 3'h0 ##1 RDATA_OUT[5]);
endmodule

bind sasc_serial sasc_serial_chk #(.DIV_W(DIV_W)) i_sasc_serial_chk (
   .SYS_CLK_IN (SYS_CLK_IN),
   .RESET_N_IN (RESET_N_IN),
   .ADDR_IN    (ADDR_IN),
   .WDATA_IN   (WDATA_IN),
   .WR_IN      (WR_IN),
   .RD_IN      (RD_IN),
   .RDATA_OUT  (RDATA_OUT),
   .RXD_IN     (RXD_IN),
   .TXD_OUT    (TXD_OUT),
   .IRQ_OUT    (IRQ_OUT)
);

// >>> verification/testbench.sv
/* self-checking bench for sasc_serial with a remote node on the line.
   assumes divisor 00 gives sixteen clocks per bit, matching the node. */
`timescale 1ns/1ps
module testbench;
   reg        clk;
   reg        rst_n;
   reg  [2:0] addr;
   reg  [7:0] wdata;
   reg        wr;
   reg        rd;
   wire [7:0] rdata;
   wire       txd;
   wire       rxd;
   wire       irq;
   reg  [7:0] d;
   integer    error_cnt;
   integer    n_compared;
   integer    k;

   sasc_serial #(.DIV_W(16)) i_sasc_serial (
      .SYS_CLK_IN (clk),
      .RESET_N_IN (rst_n),
      .ADDR_IN    (addr),
      .WDATA_IN   (wdata),
      .WR_IN      (wr),
      .RD_IN      (rd),
      .RDATA_OUT  (rdata),
      .RXD_IN     (rxd),
      .TXD_OUT    (txd),
      .IRQ_OUT    (irq)
   );
   sasc_node i_sasc_node (.txd_in(txd), .rxd_out(rxd));

   always #2 clk = ~clk;

   task chk(input string what, input [9:0] exp, input [9:0] got);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
         end
      end
   endtask

   task wr_reg(input [2:0] a, input [7:0] v);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= v;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask

   // data is registered on the edge that ends the strobe, so sample just past that edge
   task rd_reg(input [2:0] a);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1;
         d = rdata;
      end
   endtask

   task rd_chk(input [2:0] a, input [7:0] m, input [7:0] e, input string w);
      begin
         rd_reg(a);
         chk(w, {2'b00, e}, {2'b00, d & m});
      end
   endtask

   task wait_tx(input [9:0] e);
      integer n0;
      begin
         n0 = i_sasc_node.seen;
         for (k = 0; k < 800 && i_sasc_node.seen == n0; k = k + 1)
            @(posedge clk);
         chk("line frame", 10'h001, {9'h000, i_sasc_node.seen != n0});
         chk("line word", e, i_sasc_node.cap);
      end
   endtask

   task rx(input [8:0] v, input integer n, input s);
      begin
         i_sasc_node.send(v, n, s);
         repeat (4) @(posedge clk);
      end
   endtask

   task results;
      begin
         $display("compared %0d mismatches %0d", n_compared, error_cnt);
         if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask

   initial begin
      #100000;
      $display("[ERR] watchdog expected done seen timeout");
      error_cnt = error_cnt + 1;
      results;
   end

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      error_cnt = 0;
      n_compared = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(3'h0, 8'hFF, 8'hC0, "status");
      rd_chk(3'h2, 8'h7F, 8'h00, "frame");
      rd_chk(3'h3, 8'hFF, 8'h00, "enable");
      for (k = 5; k < 8; k = k + 1)
         rd_chk(k[2:0], 8'hFF, 8'h00, "unmapped");
      $display("test reset done");
      wr_reg(3'h4, 8'h00);
      wr_reg(3'h3, 8'h0C);
      rd_reg(3'h0);
      wr_reg(3'h1, 8'hA5);
      wait_tx({2'b11, 8'hA5});
      rd_chk(3'h0, 8'hC0, 8'hC0, "tx done");
      wr_reg(3'h1, 8'h3C);
      rd_chk(3'h0, 8'h40, 8'h00, "tx done clear");
      wait_tx({2'b11, 8'h3C});
      $display("test transmit done");
      rx(9'h03C, 8, 1'b1);
      rd_chk(3'h0, 8'h2F, 8'h20, "rx ready");
      rd_chk(3'h1, 8'hFF, 8'h3C, "rx data");
      rd_chk(3'h0, 8'h20, 8'h00, "rx clear");
      repeat (200) @(posedge clk);
      rd_chk(3'h0, 8'h3F, 8'h10, "idle");
      rd_reg(3'h1);
      repeat (200) @(posedge clk);
      rd_chk(3'h0, 8'h3F, 8'h00, "idle once");
      rx(9'h011, 8, 1'b1);
      rx(9'h022, 8, 1'b1);
      rd_chk(3'h0, 8'h2F, 8'h28, "overrun");
      rd_chk(3'h1, 8'hFF, 8'h11, "kept word");
      rx(9'h055, 8, 1'b0);
      rd_chk(3'h0, 8'h2F, 8'h22, "framing");
      rd_reg(3'h1);
      $display("test receive done");
      wr_reg(3'h2, 8'h04);
      rx(9'h001, 8, 1'b1);
      rd_chk(3'h0, 8'h2F, 8'h21, "parity even");
      rd_reg(3'h1);
      wr_reg(3'h2, 8'h06);
      rx(9'h001, 8, 1'b1);
      rd_chk(3'h0, 8'h2F, 8'h20, "parity odd");
      rd_reg(3'h1);
      wr_reg(3'h2, 8'h04);
      rd_reg(3'h0);
      wr_reg(3'h1, 8'h01);
      wait_tx({2'b11, 8'h81});
      $display("test parity done");
      wr_reg(3'h3, 8'h8C);
      repeat (3) @(posedge clk);
      chk("irq on", 10'h001, {9'h000, irq});
      wr_reg(3'h3, 8'h0C);
      repeat (3) @(posedge clk);
      chk("irq off", 10'h000, {9'h000, irq});
      $display("test interrupt done");
      wr_reg(3'h2, 8'h08);
      wr_reg(3'h3, 8'h0E);
      rx(9'h012, 8, 1'b1);
      rd_chk(3'h0, 8'h2F, 8'h00, "muted");
      rx(9'h085, 8, 1'b1);
      rd_chk(3'h0, 8'h20, 8'h20, "wake");
      rd_chk(3'h3, 8'hFF, 8'h0C, "mute cleared");
      wr_reg(3'h3, 8'h0E);
      rd_chk(3'h3, 8'hFF, 8'h0C, "mute locked");
      rd_reg(3'h0);
      rd_chk(3'h1, 8'hFF, 8'h85, "address word");
      wr_reg(3'h3, 8'h0D);
      wr_reg(3'h3, 8'h0C);
      wait_tx(10'h200);
      $display("test mute done");
      wr_reg(3'h2, 8'h50);
      rd_reg(3'h0);
      wr_reg(3'h1, 8'h5A);
      wait_tx({1'b1, 9'h15A});
      rx(9'h1C3, 9, 1'b1);
      rd_chk(3'h2, 8'h80, 8'h80, "rx ninth");
      rd_reg(3'h0);
      rd_chk(3'h1, 8'hFF, 8'hC3, "rx low byte");
      $display("test nine bit done");
      wr_reg(3'h3, 8'h00);
      repeat (260) @(posedge clk);
      results;
   end
endmodule
